// ===== src/indicator_pkg.sv
/*
  Constants for the indicator blink and pin select block: register indices,
  field positions, reset values, function codes and tick timing.
  Assumes a 25 MHz system clock and a simple word-wide management register port.
*/
// ----------------------------------------------------------------------------
// Function
// ----------------------------------------------------------------------------
// Function
// (RULE1) Each on-phase of the first indicator lasts its on-count times 4 ms.
// (RULE2) Each off-phase of the first indicator lasts its off-count times 4 ms.
// (RULE3) The second indicator has its own on and off counts with the same timing.
// (RULE4) Blink order zero starts with an off-phase, then an on-phase, repeating.
// (RULE5) Blink order one starts with an on-phase, then an off-phase, repeating.
// (RULE6) With both counts zero the indicator follows its selected signal live.
// (RULE7) Link-and-activity sources light while link is up and idle, else dark.
// (RULE8) Activity-only sources stay dark when idle and light on activity.
// (RULE9) Software should program every count above three.
// (RULE10) Bits 7:6 route the stamp timer to indicator zero (01) or interrupt (10).
// (RULE11) Bits 5:4 take stamp capture from indicator one (01) or the test pin (10).
// (RULE12) Bits 3:1 pick the second pin source; 111 disables the pin.
// (RULE13) Reset leaves the second pin disabled and both stamp routes unassigned.
// (RULE14) A cleared enable bit keeps its indicator dark.
// (RULE15) In order zero, present activity makes the indicator blink.
// (RULE16) A prescaler makes a one-cycle 4 ms tick that times every phase.
// (RULE17) New counts take effect no later than the start of the next phase.
package indicator_pkg;
  localparam int          CLK_HZ        = 25_000_000;
  localparam int          TICK_MS       = 4;
  localparam int          TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam logic [15:0] ADDR_PIN_SEL  = 16'h8c56;
  localparam logic [15:0] ADDR_BLINK0   = 16'h8c80;
  localparam logic [15:0] ADDR_BLINK1   = 16'h8c81;
  localparam logic [15:0] ADDR_CONTROL  = 16'h8c82;
  localparam logic [15:0] RST_PIN_SEL   = 16'h00fe;
  localparam logic [15:0] RST_BLINK     = 16'h3636;
  localparam logic [15:0] RST_CONTROL   = 16'h8e80;
  localparam logic [15:0] MASK_PIN_SEL  = 16'h00ff;
  localparam int          ON_HI         = 15;
  localparam int          ON_LO         = 8;
  localparam int          OFF_HI        = 7;
  localparam int          OFF_LO        = 0;
  localparam int          TMR_HI        = 7;
  localparam int          TMR_LO        = 6;
  localparam int          CAP_HI        = 5;
  localparam int          CAP_LO        = 4;
  localparam int          P1_HI         = 3;
  localparam int          P1_LO         = 1;
  localparam int          POL_BIT       = 0;
  // Control: upper byte for indicator one enable and function, lower byte for indicator zero and both mode bits
  localparam int          EN1_BIT       = 15;
  localparam int          FN1_HI        = 12;
  localparam int          FN1_LO        = 8;
  localparam int          EN0_BIT       = 7;
  localparam int          MODE1_BIT     = 3;
  localparam int          MODE0_BIT     = 2;
  localparam int          FN0_HI        = 4;
  localparam int          FN0_LO        = 0;
  localparam logic [1:0]  ROUTE_A       = 2'h1;
  localparam logic [1:0]  ROUTE_B       = 2'h2;
  localparam logic [2:0]  P1_INDICATOR  = 3'h0;
  localparam logic [2:0]  P1_LINK       = 3'h6;
  localparam logic [2:0]  P1_OFF        = 3'h7;
  localparam logic [4:0]  FN_LINK_TXRX  = 5'h00;
  localparam logic [4:0]  FN_LINK_TX    = 5'h01;
  localparam logic [4:0]  FN_LINK_RX    = 5'h02;
  localparam logic [4:0]  FN_LINK_ONLY  = 5'h03;
  localparam logic [4:0]  FN_TXRX       = 5'h04;
  localparam logic [4:0]  FN_TX         = 5'h05;
  localparam logic [4:0]  FN_RX         = 5'h06;
  localparam logic [4:0]  FN_ON         = 5'h07;
  localparam logic [4:0]  FN_OFF        = 5'h08;
  localparam logic [4:0]  FN_BLINK      = 5'h09;
  typedef enum logic [1:0] {PH_IDLE = 2'b00, PH_FIRST = 2'b01, PH_SECOND = 2'b11} phase_e;
endpackage

// ===== src/indicator_blink_and_pin_select.sv
/*
  Indicator blink timing, source selection and pin routing, with the four
  management registers. Assumes activity, link and transmit-interface inputs come
  from unrelated logic or pins, so all are synchronised; register port is synchronous.
*/
module indicator_blink_and_pin_select
  import indicator_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
)(
  input  wire logic        CLK_I,
  input  wire logic        RESETN_I,
  input  wire logic        REG_WE_I,
  input  wire logic        REG_RE_I,
  input  wire logic [15:0] REG_ADDR_I,
  input  wire logic [15:0] REG_WDATA_I,
  output logic      [15:0] REG_RDATA_O,
  output logic             REG_HIT_O,
  input  wire logic        LINK_UP_I,
  input  wire logic        TX_ACT_I,
  input  wire logic        RX_ACT_I,
  input  wire logic [4:0]  TXIF_I,
  input  wire logic        STAMP_TIMER_I,
  input  wire logic        PIN_ONE_IN_I,
  input  wire logic        TEST_PIN_IN_I,
  output logic             STAMP_CAPTURE_O,
  output logic             INDICATOR_PIN_ZERO_O,
  output logic             INDICATOR_PIN_ONE_O,
  output logic             INDICATOR_PIN_ONE_OE_O,
  output logic             INT_STAMP_O,
  output logic             INT_STAMP_OE_O
);
  // --------------------------------------------------------------------------
  // Reset release and input synchronisers
  // --------------------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  localparam int NIN = 11;
  logic [NIN-1:0] meta_q;
  logic [NIN-1:0] sync_q;
  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= {TEST_PIN_IN_I, PIN_ONE_IN_I, STAMP_TIMER_I, TXIF_I,
                 RX_ACT_I, TX_ACT_I, LINK_UP_I};
      sync_q <= meta_q;
    end
  end
  logic       link_s;
  logic       tx_s;
  logic       rx_s;
  logic [4:0] txif_s;
  logic       timer_s;
  logic       pin1_s;
  logic       test_s;
  assign {test_s, pin1_s, timer_s, txif_s, rx_s, tx_s, link_s} = sync_q;

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [15:0] pin_sel_q;
  logic [15:0] pin_sel_d;
  logic [15:0] blink_q [2];
  logic [15:0] blink_d [2];
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;

  always_comb
  begin
    pin_sel_d  = pin_sel_q;
    blink_d[0] = blink_q[0];
    blink_d[1] = blink_q[1];
    ctrl_d     = ctrl_q;
    if (REG_WE_I)
    begin
      unique case (REG_ADDR_I)
        ADDR_PIN_SEL: pin_sel_d  = REG_WDATA_I & MASK_PIN_SEL;
        ADDR_BLINK0:  blink_d[0] = REG_WDATA_I;
        ADDR_BLINK1:  blink_d[1] = REG_WDATA_I;
        ADDR_CONTROL: ctrl_d     = REG_WDATA_I;
        default:      ctrl_d     = ctrl_q;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_sel_q <= RST_PIN_SEL; // [RULE13]
      blink_q[0] <= RST_BLINK;
      blink_q[1] <= RST_BLINK;
      ctrl_q <= RST_CONTROL;
    end
    else
    begin
      pin_sel_q <= pin_sel_d;
      blink_q[0] <= blink_d[0];
      blink_q[1] <= blink_d[1];
      ctrl_q <= ctrl_d;
    end
  end

  // Unmapped reads return zero with the hit flag low
  always_comb
  begin
    REG_HIT_O   = 1'b1;
    REG_RDATA_O = 16'h0000;
    unique case (REG_ADDR_I)
      ADDR_PIN_SEL: REG_RDATA_O = pin_sel_q;
      ADDR_BLINK0:  REG_RDATA_O = blink_q[0];
      ADDR_BLINK1:  REG_RDATA_O = blink_q[1];
      ADDR_CONTROL: REG_RDATA_O = ctrl_q;
      default:      REG_HIT_O   = 1'b0;
    endcase
    if (!REG_RE_I)
    begin
      REG_RDATA_O = 16'h0000;
      REG_HIT_O   = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // 4 ms tick
  // --------------------------------------------------------------------------
  logic [31:0] pre_q;
  logic [31:0] pre_d;
  logic        tick;
  always_comb
  begin
    tick  = (pre_q == 32'(TICK_LEN - 1));
    pre_d = tick ? 32'h0 : pre_q + 32'h1; // [RULE16]
  end
  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      pre_q <= 32'h0;
    else
      pre_q <= pre_d;
  end

  // --------------------------------------------------------------------------
  // Per-indicator source and blink engine
  // --------------------------------------------------------------------------
  logic [1:0] lit;
  logic [1:0] lit_q;
  phase_e     ph_q  [2];
  phase_e     ph_d  [2];
  logic [7:0] cnt_q [2];
  logic [7:0] cnt_d [2];
  logic [1:0] act;
  logic [1:0] is_blink;
  logic [1:0] live;

  for (genvar g = 0; g < 2; g++)
  begin : g_ind
    logic [4:0] fn;
    logic       mode;
    logic       en;
    logic [7:0] on_c;
    logic [7:0] off_c;
    logic       first_on;
    logic [7:0] first_len;
    logic [7:0] second_len;
    assign fn    = (g == 0) ? ctrl_q[FN0_HI:FN0_LO] : ctrl_q[FN1_HI:FN1_LO];
    assign mode  = (g == 0) ? ctrl_q[MODE0_BIT] : ctrl_q[MODE1_BIT];
    assign en    = (g == 0) ? ctrl_q[EN0_BIT] : ctrl_q[EN1_BIT];
    assign on_c  = blink_q[g][ON_HI:ON_LO];   // [RULE1] [RULE3]
    assign off_c = blink_q[g][OFF_HI:OFF_LO]; // [RULE2] [RULE3]
    // Mode zero starts dark, mode one starts lit
    assign first_on   = mode;                 // [RULE4] [RULE5]
    assign first_len  = first_on ? on_c : off_c;
    assign second_len = first_on ? off_c : on_c;

    always_comb
    begin
      act[g]      = 1'b0;
      is_blink[g] = 1'b0;
      live[g]     = 1'b0;
      unique case (fn)
        FN_LINK_TXRX: live[g] = link_s & ~(tx_s | rx_s); // [RULE7]
        FN_LINK_TX:   live[g] = link_s & ~tx_s;          // [RULE7]
        FN_LINK_RX:   live[g] = link_s & ~rx_s;          // [RULE7]
        FN_LINK_ONLY: live[g] = link_s;
        FN_TXRX:      act[g]  = tx_s | rx_s;             // [RULE8]
        FN_TX:        act[g]  = tx_s;                    // [RULE8]
        FN_RX:        act[g]  = rx_s;                    // [RULE8]
        FN_ON:        live[g] = 1'b1;
        FN_BLINK:     is_blink[g] = 1'b1;
        default:      live[g] = 1'b0;
      endcase
    end

    // Blink runs for the blink function, or for activity sources in mode zero
    logic run;
    logic zero_cnt;
    assign zero_cnt = (on_c == 8'h00) && (off_c == 8'h00);
    assign run = !zero_cnt && (is_blink[g] || (act[g] && !mode)); // [RULE15]

    always_comb
    begin
      ph_d[g]  = ph_q[g];
      cnt_d[g] = cnt_q[g];
      if (!run)
      begin
        ph_d[g]  = PH_IDLE;
        cnt_d[g] = 8'h00;
      end
      else
      begin
        unique case (ph_q[g])
          PH_IDLE:
          begin
            ph_d[g]  = PH_FIRST;
            cnt_d[g] = first_len;
          end
          PH_FIRST, PH_SECOND:
          begin
            // Lengths are sampled at phase start so edits land on the next phase
            if (cnt_q[g] == 8'h00)
            begin
              ph_d[g]  = (ph_q[g] == PH_FIRST) ? PH_SECOND : PH_FIRST; // [RULE17]
              cnt_d[g] = (ph_q[g] == PH_FIRST) ? second_len : first_len;
            end
            else if (tick)
              cnt_d[g] = cnt_q[g] - 8'h01;
          end
          default: ph_d[g] = PH_IDLE;
        endcase
      end
    end

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
      if (!rst_n)
      begin
        ph_q[g]  <= PH_IDLE;
        cnt_q[g] <= 8'h00;
      end
      else
      begin
        ph_q[g]  <= ph_d[g];
        cnt_q[g] <= cnt_d[g];
      end
    end

    always_comb
    begin
      if (!en)
        lit[g] = 1'b0;                                   // [RULE14]
      else if (run)
        lit[g] = (ph_q[g] == PH_FIRST) ? first_on : ((ph_q[g] == PH_SECOND) && !first_on);
      else if (zero_cnt && is_blink[g])
        lit[g] = 1'b0;
      else
        lit[g] = live[g] | act[g];                       // [RULE6] [RULE8]
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
      lit_q <= 2'h0;
    else
      lit_q <= lit;
  end

  // --------------------------------------------------------------------------
  // Pin routing
  // --------------------------------------------------------------------------
  logic [1:0] tmr_route;
  logic [1:0] cap_route;
  logic [2:0] p1_route;
  logic       link_pin;
  logic       p1_val;
  assign tmr_route = pin_sel_q[TMR_HI:TMR_LO];
  assign cap_route = pin_sel_q[CAP_HI:CAP_LO];
  assign p1_route  = pin_sel_q[P1_HI:P1_LO];
  assign link_pin  = link_s ^ pin_sel_q[POL_BIT];

  always_comb
  begin
    unique case (p1_route)                               // [RULE12]
      P1_INDICATOR: p1_val = lit_q[1];
      P1_LINK:      p1_val = link_pin;
      P1_OFF:       p1_val = 1'b0;
      default:      p1_val = txif_s[p1_route - 3'h1];
    endcase
  end

  logic [4:0] out_d;
  logic [4:0] out_q;
  always_comb
  begin
    out_d[0] = (tmr_route == ROUTE_A) ? timer_s : lit_q[0]; // [RULE10]
    out_d[1] = (tmr_route == ROUTE_B) ? timer_s : 1'b0;     // [RULE10]
    out_d[2] = (tmr_route == ROUTE_B);
    // Capture pin one only when it is not being driven
    out_d[3] = (cap_route == ROUTE_A) ? pin1_s :
               (cap_route == ROUTE_B) ? test_s : 1'b0;      // [RULE11]
    out_d[4] = (p1_route != P1_OFF) && (cap_route != ROUTE_A);
  end

  logic p1_q;
  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_q <= 5'h00;
      p1_q  <= 1'b0;
    end
    else
    begin
      out_q <= out_d;
      p1_q  <= p1_val;
    end
  end

  assign INDICATOR_PIN_ZERO_O   = out_q[0];
  assign INT_STAMP_O            = out_q[1];
  assign INT_STAMP_OE_O         = out_q[2];
  assign STAMP_CAPTURE_O        = out_q[3];
  assign INDICATOR_PIN_ONE_OE_O = out_q[4];
  assign INDICATOR_PIN_ONE_O    = p1_q;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_tick_period: assert property (@(posedge CLK_I) disable iff (!rst_n)
    tick |-> ##1 !tick) else $error("tick not single cycle"); // [RULE16]
  a_disable_dark: assert property (@(posedge CLK_I) disable iff (!rst_n)
    !ctrl_q[EN0_BIT] |-> ##1 !lit_q[0]) else $error("disabled indicator lit"); // [RULE14]
  a_pin_off: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (p1_route == P1_OFF) |=> !INDICATOR_PIN_ONE_OE_O) else $error("pin one driven"); // [RULE12]
  a_timer_zero: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (tmr_route == ROUTE_A) |=> INDICATOR_PIN_ZERO_O == $past(timer_s))
    else $error("timer route"); // [RULE10]
  a_capture_test: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (cap_route == ROUTE_B) |=> STAMP_CAPTURE_O == $past(test_s))
    else $error("capture route"); // [RULE11]
  a_first_order: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (ph_q[0] == PH_IDLE) ##1 (ph_q[0] == PH_FIRST) |-> cnt_q[0] == $past(g_ind[0].first_len))
    else $error("first phase length"); // [RULE4]
  a_phase_count: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (ph_q[1] != PH_IDLE) && tick && cnt_q[1] != 8'h00 && g_ind[1].run
    |=> cnt_q[1] == $past(cnt_q[1]) - 8'h01) else $error("phase count"); // [RULE3]
  a_live_follow: assert property (@(posedge CLK_I) disable iff (!rst_n)
    ctrl_q[EN0_BIT] && g_ind[0].zero_cnt && !is_blink[0] |-> lit[0] == (live[0] | act[0]))
    else $error("live monitor"); // [RULE6]
  a_reset_sel: assert property (@(posedge CLK_I) $rose(rst_n) |-> pin_sel_q == RST_PIN_SEL)
    else $error("reset select"); // [RULE13]
  c_blink: cover property (@(posedge CLK_I) disable iff (!rst_n) ph_q[0] == PH_SECOND);
  c_wrap: cover property (@(posedge CLK_I) disable iff (!rst_n)
    ph_q[1] == PH_SECOND ##1 ph_q[1] == PH_FIRST);
  c_pin_link: cover property (@(posedge CLK_I) disable iff (!rst_n) p1_route == P1_LINK);
endmodule

// ===== testbench/indicator_led_model.sv
/*
  Model of an indicator lamp on one output pin: measures the length of each lit
  and dark run in clock cycles and counts level changes.
  Assumes the pin is sampled on the block's own clock.
*/
module indicator_led_model
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic level_i,
  output int        on_len_o,
  output int        off_len_o,
  output int        edges_o
);
  timeunit 1ns;
  timeprecision 1ns;

  int   run_q;
  logic prev_q;

  // A lamp only shows what reaches it, so the last completed runs are kept
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      run_q     <= 0;
      prev_q    <= 1'b0;
      on_len_o  <= 0;
      off_len_o <= 0;
      edges_o   <= 0;
    end
    else if (level_i !== prev_q)
    begin
      if (prev_q === 1'b1)
        on_len_o <= run_q;
      else
        off_len_o <= run_q;
      run_q   <= 1;
      prev_q  <= level_i;
      edges_o <= edges_o + 1;
    end
    else
      run_q <= run_q + 1;
  end
endmodule

// ===== testbench/indicator_blink_and_pin_select_tb_top.sv
/*
  Self-checking bench for the indicator blink and pin select block: register
  access, blink timing and order, live sources and pin routing.
  Assumes a short tick (TL cycles) in place of the 4 ms count.
*/
`define CHECK(nm, e, g) check_val(nm, 16'(e), 16'(g))
module indicator_blink_and_pin_select_tb_top
  import indicator_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TL = 10;

  logic        clk, rst_n, we, re, link, tx, rx, tmr, ext_en, ext_val, tpin;
  logic [15:0] addr, wdata, rdata, rd;
  logic        hit, cap, pin0, pin1, oe1, irq, irq_oe, h;
  logic [4:0]  txif;
  wire         pin1_w = oe1 ? pin1 : (ext_en ? ext_val : 1'b0);  // Pulled down when released
  int          num_errors, n_tests, on0, off0, ed0, on1, off1, ed1, e;

  indicator_blink_and_pin_select #(.TICK_LEN(TL)) uut (
    .CLK_I(clk), .RESETN_I(rst_n), .REG_WE_I(we), .REG_RE_I(re), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_HIT_O(hit), .LINK_UP_I(link),
    .TX_ACT_I(tx), .RX_ACT_I(rx), .TXIF_I(txif), .STAMP_TIMER_I(tmr),
    .PIN_ONE_IN_I(pin1_w), .TEST_PIN_IN_I(tpin), .STAMP_CAPTURE_O(cap),
    .INDICATOR_PIN_ZERO_O(pin0), .INDICATOR_PIN_ONE_O(pin1),
    .INDICATOR_PIN_ONE_OE_O(oe1), .INT_STAMP_O(irq), .INT_STAMP_OE_O(irq_oe));

  indicator_led_model lamp0 (.clk_i(clk), .rst_n_i(rst_n), .level_i(pin0),
    .on_len_o(on0), .off_len_o(off0), .edges_o(ed0));
  indicator_led_model lamp1 (.clk_i(clk), .rst_n_i(rst_n), .level_i(pin1_w),
    .on_len_o(on1), .off_len_o(off1), .edges_o(ed1));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  task automatic print_verdict();
    if (num_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check_val(input string nm, input logic [15:0] ex, input logic [15:0] got);
    n_tests++;
    if (got !== ex)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    we    = 1'b1;
    addr  = a;
    wdata = d;
    @(negedge clk);
    we = 1'b0;
  endtask

  task automatic reg_read(input logic [15:0] a, output logic [15:0] d, output logic ht);
    @(negedge clk);
    re   = 1'b1;
    addr = a;
    @(posedge clk);
    d  = rdata;
    ht = hit;
    @(negedge clk);
    re = 1'b0;
  endtask

  // Lamp run length must exceed n-1 ticks and be at most n ticks plus two cycles (free-running prescaler)
  function automatic logic in_rng(input int len, input int n);
    return (len > (n - 1) * TL) && (len <= n * TL + 2);
  endfunction

  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    print_verdict();
  end

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial
  begin
    {rst_n, we, re, link, tx, rx, tmr, ext_en, ext_val, tpin} = '0;
    {addr, wdata, txif} = '0;
    num_errors = 0;
    n_tests    = 0;
    cyc(6);
    rst_n = 1'b1;
    cyc(3);
    reg_read(ADDR_PIN_SEL, rd, h);
    `CHECK("pin_sel reset", RST_PIN_SEL, rd);
    `CHECK("pin_sel hit", 1'b1, h);
    `CHECK("pin1 oe reset", 1'b0, oe1);
    reg_read(ADDR_BLINK0, rd, h);
    `CHECK("blink0 reset", RST_BLINK, rd);
    reg_read(ADDR_BLINK1, rd, h);
    `CHECK("blink1 reset", RST_BLINK, rd);
    reg_read(ADDR_CONTROL, rd, h);
    `CHECK("control reset", RST_CONTROL, rd);
    reg_write(16'h8c57, 16'h1234);
    reg_read(16'h8c57, rd, h);
    `CHECK("unmapped data", 16'h0000, rd);
    `CHECK("unmapped hit", 1'b0, h);
    reg_write(ADDR_PIN_SEL, 16'hffff);
    reg_read(ADDR_PIN_SEL, rd, h);
    `CHECK("pin_sel mask", MASK_PIN_SEL, rd);

    // Blink: order zero on lamp zero, order one on lamp one; counts above three
    reg_write(ADDR_BLINK0, 16'h0406);
    reg_write(ADDR_BLINK1, 16'h0705);
    reg_read(ADDR_BLINK0, rd, h);
    `CHECK("blink0 rdback", 16'h0406, rd);
    reg_write(ADDR_PIN_SEL, 16'h00f0);
    reg_write(ADDR_CONTROL, 16'h8989);
    cyc(10);
    `CHECK("order1 starts lit", 1'b1, pin1_w);
    `CHECK("order0 starts dark", 1'b0, pin0);
    cyc(30);
    `CHECK("order0 still dark", 1'b0, pin0);
    cyc(40);
    `CHECK("order0 then lit", 1'b1, pin0);
    cyc(400);
    `CHECK("on0 length", 1'b1, in_rng(on0, 4));
    `CHECK("off0 length", 1'b1, in_rng(off0, 6));
    `CHECK("on1 length", 1'b1, in_rng(on1, 7));
    `CHECK("off1 length", 1'b1, in_rng(off1, 5));
    reg_write(ADDR_BLINK0, 16'h0508);
    cyc(400);
    `CHECK("new on0", 1'b1, in_rng(on0, 5));
    `CHECK("new off0", 1'b1, in_rng(off0, 8));

    // Activity-only source in order zero blinks while active (lamp one)
    reg_write(ADDR_CONTROL, 16'h8000 | 16'({FN_TX, 8'h00}));
    tx = 1'b1;
    cyc(20);
    e = ed1;
    cyc(300);
    `CHECK("active blinks", 1'b1, (ed1 - e) >= 3);

    // Both counts zero: live sources
    reg_write(ADDR_CONTROL, 16'h0080 | 16'(FN_LINK_TX));
    reg_write(ADDR_BLINK0, 16'h0000);
    link = 1'b1;
    tx   = 1'b0;
    cyc(6);
    `CHECK("link idle lit", 1'b1, pin0);
    tx = 1'b1;
    cyc(6);
    `CHECK("link active dark", 1'b0, pin0);
    {tx, link} = 2'b00;
    cyc(6);
    `CHECK("link lost dark", 1'b0, pin0);
    reg_write(ADDR_CONTROL, 16'h0080 | 16'(FN_TX));
    tx = 1'b1;
    cyc(6);
    `CHECK("act lit", 1'b1, pin0);
    tx = 1'b0;
    cyc(6);
    `CHECK("act idle dark", 1'b0, pin0);
    reg_write(ADDR_CONTROL, 16'h0080 | 16'(FN_RX));
    rx = 1'b1;
    cyc(6);
    `CHECK("rx act lit", 1'b1, pin0);
    reg_write(ADDR_CONTROL, 16'h0080 | 16'(FN_LINK_TXRX));
    link = 1'b1;
    cyc(6);
    `CHECK("link rx dark", 1'b0, pin0);
    rx = 1'b0;
    cyc(6);
    `CHECK("link txrx idle lit", 1'b1, pin0);
    reg_write(ADDR_CONTROL, 16'h0080 | 16'(FN_ON));
    cyc(6);
    `CHECK("enabled on", 1'b1, pin0);
    reg_write(ADDR_CONTROL, 16'(FN_ON));
    cyc(6);
    `CHECK("disabled dark", 1'b0, pin0);

    // Pin one sources, codes 1 to 5 from the transmit interface
    for (int k = 1; k <= 5; k++)
    begin
      reg_write(ADDR_PIN_SEL, 16'h00f0 | 16'(k << 1));
      txif = 5'h01 << (k - 1);
      cyc(6);
      `CHECK("txif sel hi", 2'b11, {oe1, pin1});
      txif = ~(5'h01 << (k - 1));
      cyc(6);
      `CHECK("txif sel lo", 2'b10, {oe1, pin1});
    end
    link = 1'b1;
    reg_write(ADDR_PIN_SEL, 16'h00f0 | 16'({P1_LINK, 1'b0}));
    cyc(6);
    `CHECK("link high pol", 1'b1, pin1_w);
    reg_write(ADDR_PIN_SEL, 16'h00f0 | 16'({P1_LINK, 1'b1}));
    cyc(6);
    `CHECK("link low pol", 1'b0, pin1_w);
    reg_write(ADDR_PIN_SEL, 16'h00fe);
    cyc(6);
    `CHECK("pin1 disabled", 1'b0, oe1);

    // Stamp routes
    reg_write(ADDR_PIN_SEL, 16'h007e);
    tmr = 1'b1;
    cyc(6);
    `CHECK("timer on pin0", 2'b10, {pin0, irq_oe});
    reg_write(ADDR_PIN_SEL, 16'h00be);
    cyc(6);
    `CHECK("timer on int", 2'b11, {irq, irq_oe});
    tmr = 1'b0;
    cyc(6);
    `CHECK("timer int low", 1'b0, irq);
    reg_write(ADDR_PIN_SEL, 16'h00de);
    {ext_en, ext_val} = 2'b11;
    cyc(6);
    `CHECK("capt from pin1", 1'b1, cap);
    reg_write(ADDR_PIN_SEL, 16'h00ee);
    tpin = 1'b1;
    cyc(6);
    `CHECK("capt from test", 1'b1, cap);
    tpin = 1'b0;
    cyc(6);
    `CHECK("capt test low", 1'b0, cap);
    print_verdict();
  end
endmodule
